// >>> common/pgdss_pkg.sv
// Shared constants and types of the power-good, shutdown and sleep control block
package pgdss_pkg;
    // ==========================================================
    // Register map (byte pointer of the serial bus)
    localparam logic [7:0] ADDR_PG_DELAY  = 8'h43;
    localparam logic [7:0] ADDR_FORCE_SD  = 8'h91;
    localparam logic [7:0] ADDR_REG1_SLP  = 8'h92;
    localparam logic [7:0] ADDR_REG2_SLP  = 8'h93;

    // ==========================================================
    // Field layout and reset values
    localparam int         PG_SEL_W       = 3;
    localparam int         CODE_W         = 7;
    localparam int         SLP_EN_BIT     = 0;
    localparam int         SLP_CODE_LSB   = 1;
    localparam int         FORCE_SD_BIT   = 0;
    localparam logic [2:0] PG_SEL_RESET   = 3'h0;
    localparam logic [7:0] SLP_CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;
    localparam logic [4:0] PG_RSVD_BITS   = 5'h00;
    localparam logic [3:0] SYNC_RESET     = 4'hf;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam int         NUM_REGS       = 2;

    // ==========================================================
    // Timing: power-good delays in microseconds, clock in MHz
    localparam int         CLK_MHZ        = 50;
    localparam int         PG_DELAY_US [8] = '{2500, 5000, 10000, 15000,
                                               20000, 50000, 75000, 100000};
    localparam int         PG_CNT_W       = 23;

    // ==========================================================
    // Serial bus slave states, Gray coded along a write
    typedef enum logic [3:0] {
        PGDSS_IDLE   = 4'h0,
        PGDSS_ADDR   = 4'h1,
        PGDSS_AACK   = 4'h3,
        PGDSS_PTR    = 4'h2,
        PGDSS_PACK   = 4'h6,
        PGDSS_WDATA  = 4'h7,
        PGDSS_WACK   = 4'h5,
        PGDSS_RDATA  = 4'h4,
        PGDSS_RACK   = 4'hc
    } pgdss_bus_st_t;
endpackage

// >>> verilog/pgdss_pg_timer.sv
// Power-good assertion delay timer for the third general-purpose output
`timescale 1ns/1ps
module pgdss_pg_timer
    import pgdss_pkg::*;
#(
    parameter int US_CYCLES = CLK_MHZ
)
(
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                reset_i,
    // Control
    input  wire logic                rails_good_i,
    input  wire logic [PG_SEL_W-1:0] delay_sel_i,
    input  wire logic                bypass_i,
    input  wire logic                bus_level_i,
    // Output
    output logic                     pg_o
);
    typedef struct packed {
        logic [PG_CNT_W-1:0] cnt;
        logic                pg;
    } pgdss_tmr_st_t;

    pgdss_tmr_st_t q;
    pgdss_tmr_st_t next_q;
    logic [PG_CNT_W-1:0] target;

    // exact nominal count
    // Nominal cycle count; exact nominal sits well inside the tolerance band
    assign target = PG_CNT_W'(PG_DELAY_US[delay_sel_i] * US_CYCLES);

    // Count only while every grouped rail is in regulation
    always_comb
    begin
        next_q = q;
        if (bypass_i)
        begin
            next_q.cnt = '0;
            next_q.pg  = bus_level_i;
        end
        else if (!rails_good_i)
        begin
            next_q.cnt = '0;
            next_q.pg  = 1'b0;
        end
        else if (!q.pg)
        begin
            if (q.cnt == target - PG_CNT_W'(1))
                next_q.pg = 1'b1;
            else
                next_q.cnt = q.cnt + PG_CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign pg_o = q.pg;

    // ==========================================================
    // Checks
    a_pg_needs_rails: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(q.pg) && !$past(bypass_i) |-> $past(rails_good_i))
        else $error("power good rose without rails good");
    a_pg_delay_count: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(q.pg) && !$past(bypass_i) |-> $past(q.cnt) == $past(target) - PG_CNT_W'(1))
        else $error("power good delay count wrong");
    a_pg_bypass_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        bypass_i |=> pg_o == $past(bus_level_i))
        else $error("bus-driven output not followed");
    c_pg_asserted: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(q.pg) && !bypass_i);
endmodule

// >>> verilog/pgdss_sleep_sel.sv
// Normal or sleep voltage code selection for one step-down regulator
`timescale 1ns/1ps
module pgdss_sleep_sel
    import pgdss_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    // Settings
    input  wire logic              sleep_en_i,
    input  wire logic              pin_sel_i,
    input  wire logic [CODE_W-1:0] sleep_code_i,
    input  wire logic [CODE_W-1:0] normal_code_i,
    // Synchronised sleep pins
    input  wire logic              pin_a_i,
    input  wire logic              pin_b_i,
    // Outputs
    output logic [CODE_W-1:0]      code_o,
    output logic                   sleep_o
);
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic              sleep;
    } pgdss_slp_st_t;

    pgdss_slp_st_t q;
    pgdss_slp_st_t next_q;
    logic          pin;

    assign pin = pin_sel_i ? pin_b_i : pin_a_i;

    // Sleep pin is active low
    always_comb
    begin
        next_q.sleep = sleep_en_i & ~pin;
        next_q.code  = next_q.sleep ? sleep_code_i : normal_code_i;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign code_o  = q.code;
    assign sleep_o = q.sleep;

    // ==========================================================
    // Checks
    a_sleep_off_normal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !sleep_en_i |=> !sleep_o && code_o == $past(normal_code_i))
        else $error("disabled regulator left normal code");
    a_sleep_pin_low: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sleep_en_i && !pin |=> sleep_o && code_o == $past(sleep_code_i))
        else $error("sleep code not applied");
    a_sleep_pin_high: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sleep_en_i && (pin_sel_i ? pin_b_i : pin_a_i) |=> !sleep_o)
        else $error("sleep taken while assigned pin high");
    c_sleep_enter: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(sleep_o));
endmodule

// >>> verilog/pgdss_top.sv
// Serial-bus registers, forced shutdown, power-good delay and sleep selection
//
// Contract
// - Power-good delay chosen by 3-bit code: 2.5 to 100 ms.
// - Delay starts only once all grouped rails are in regulation.
// - Each delay may deviate ten percent from nominal.
// - Bus-driven output not used for termination enable ignores delay code.
// - Writing 1 to bit 0 starts emergency shutdown; 0 does nothing.
// - Shutdown resets the device and all registers.
// - Shutdown bit clears itself.
// - The write setting the shutdown bit gets no acknowledge.
// - Sleep enable 0 means normal voltage code always.
// - Sleep enable 1 uses sleep code while assigned pin is low.
// - Each regulator follows one of two sleep pins, fixed at factory.
// - Sleep code is 7 bits in bits 7:1, 25 mV steps.
`timescale 1ns/1ps
module pgdss_top
    import pgdss_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = 7'h5e,   // Bus address, arbitrary value
    parameter int         US_CYCLES = CLK_MHZ  // Cycles per microsecond of delay
)
(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    // Serial bus pins
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    // Sleep pins and factory choice
    input  wire logic              sleep_pin_a_i,
    input  wire logic              sleep_pin_b_i,
    input  wire logic              reg1_pin_sel_i,
    input  wire logic              reg2_pin_sel_i,
    // Normal voltage codes
    input  wire logic [CODE_W-1:0] reg1_normal_voltage_code_i,
    input  wire logic [CODE_W-1:0] reg2_normal_voltage_code_i,
    // Power-good source
    input  wire logic              rails_good_i,
    input  wire logic              pg_src_bus_i,
    input  wire logic              pg_vtt_use_i,
    input  wire logic              pg_bus_level_i,
    // Outputs
    output logic                   power_good_out_c_o,
    output logic [CODE_W-1:0]      reg1_voltage_code_o,
    output logic                   reg1_sleep_o,
    output logic [CODE_W-1:0]      reg2_voltage_code_o,
    output logic                   reg2_sleep_o,
    output logic                   shutdown_o
);
    // ==========================================================
    // Elaboration checks
    if (US_CYCLES < 1 || US_CYCLES > 80)
    begin : g_bad_rate
        $error("US_CYCLES out of range");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [3:0]          sy1;      // First sync stage
        logic [3:0]          sy2;      // Second sync stage
        logic                scl_q;
        logic                sda_q;
        pgdss_bus_st_t       st;
        logic [3:0]          bits;
        logic [7:0]          shreg;
        logic [7:0]          ptr;
        logic                rw;
        logic                nack;
        logic                oe;
        logic                shutdown;
        logic [PG_SEL_W-1:0] pg_sel;
        logic [7:0]          slp1;
        logic [7:0]          slp2;
    } pgdss_top_st_t;

    localparam pgdss_top_st_t ST_RESET = '{
        sy1: SYNC_RESET, sy2: SYNC_RESET, scl_q: 1'b1, sda_q: 1'b1,
        st: PGDSS_IDLE, bits: 4'h0, shreg: 8'h00, ptr: 8'h00, rw: 1'b0,
        nack: 1'b0, oe: 1'b0, shutdown: 1'b0, pg_sel: PG_SEL_RESET,
        slp1: SLP_CTRL_RESET, slp2: SLP_CTRL_RESET};

    pgdss_top_st_t q;
    pgdss_top_st_t next_q;

    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    // Only the second sync stage is looked at
    assign scl_s = q.sy2[0];
    assign sda_s = q.sy2[1];
    assign rise  = scl_s & ~q.scl_q;
    assign fall  = ~scl_s & q.scl_q;
    assign start = scl_s & q.scl_q & q.sda_q & ~sda_s;
    assign stop  = scl_s & q.scl_q & ~q.sda_q & sda_s;

    // Read data for the current pointer; shutdown bit always reads zero
    function automatic logic [7:0] read_reg(input pgdss_top_st_t s, input logic [7:0] a);
        logic [7:0] d;
        d = READ_ZERO;
        case (a)
            ADDR_PG_DELAY: d = {PG_RSVD_BITS, s.pg_sel};
            ADDR_REG1_SLP: d = s.slp1;
            ADDR_REG2_SLP: d = s.slp2;
            default:       d = READ_ZERO;
        endcase
        return d;
    endfunction

    // ==========================================================
    // Serial bus slave and register file
    always_comb
    begin
        next_q          = q;
        next_q.sy1      = {sleep_pin_b_i, sleep_pin_a_i, sda_i, scl_i};
        next_q.sy2      = q.sy1;
        next_q.scl_q    = scl_s;
        next_q.sda_q    = sda_s;
        next_q.shutdown = 1'b0;
        if (rise && q.st != PGDSS_IDLE)
        begin
            next_q.shreg = {q.shreg[6:0], sda_s};
            next_q.bits  = q.bits + 4'h1;
            next_q.nack  = sda_s;
        end
        // Start and stop win over any byte in progress
        if (start)
        begin
            next_q.st   = PGDSS_ADDR;
            next_q.bits = 4'h0;
            next_q.oe   = 1'b0;
        end
        else if (stop)
        begin
            next_q.st = PGDSS_IDLE;
            next_q.oe = 1'b0;
        end
        else if (fall)
        begin
            case (q.st)
                PGDSS_IDLE:
                    next_q.oe = 1'b0;
                PGDSS_ADDR:
                    if (q.bits == BITS_PER_BYTE)
                    begin
                        if (q.shreg[7:1] == DEV_ADDR)
                        begin
                            next_q.st = PGDSS_AACK;
                            next_q.oe = 1'b1;
                            next_q.rw = q.shreg[0];
                        end
                        else
                            next_q.st = PGDSS_IDLE;
                    end
                PGDSS_AACK:
                begin
                    next_q.bits = 4'h0;
                    if (q.rw)
                    begin
                        next_q.shreg = read_reg(q, q.ptr);
                        next_q.oe    = ~next_q.shreg[7];
                        next_q.st    = PGDSS_RDATA;
                    end
                    else
                    begin
                        next_q.oe = 1'b0;
                        next_q.st = PGDSS_PTR;
                    end
                end
                PGDSS_PTR:
                    if (q.bits == BITS_PER_BYTE)
                    begin
                        next_q.ptr = q.shreg;
                        next_q.oe  = 1'b1;
                        next_q.st  = PGDSS_PACK;
                    end
                PGDSS_PACK, PGDSS_WACK:
                begin
                    next_q.oe   = 1'b0;
                    next_q.bits = 4'h0;
                    next_q.st   = PGDSS_WDATA;
                    if (q.st == PGDSS_WACK)
                        next_q.ptr = q.ptr + 8'h01;
                end
                PGDSS_WDATA:
                    if (q.bits == BITS_PER_BYTE)
                    begin
                        next_q.oe = 1'b1;
                        next_q.st = PGDSS_WACK;
                        case (q.ptr)
                            ADDR_PG_DELAY: next_q.pg_sel = q.shreg[PG_SEL_W-1:0];
                            ADDR_REG1_SLP: next_q.slp1 = q.shreg;
                            ADDR_REG2_SLP: next_q.slp2 = q.shreg;
                            default:       next_q.oe = 1'b1;
                        endcase
                        if (q.ptr == ADDR_FORCE_SD && q.shreg[FORCE_SD_BIT])
                        begin
                            next_q          = ST_RESET;
                            next_q.shutdown = 1'b1;
                        end
                    end
                PGDSS_RDATA:
                    if (q.bits == BITS_PER_BYTE)
                    begin
                        next_q.oe  = 1'b0;
                        next_q.ptr = q.ptr + 8'h01;
                        next_q.st  = PGDSS_RACK;
                    end
                    else
                    begin
                        // The rising edge has already shifted, so the next bit sits on top
                        next_q.oe = ~q.shreg[7];
                    end
                PGDSS_RACK:
                    // Host not acknowledging ends the read
                    if (q.nack)
                        next_q.st = PGDSS_IDLE;
                    else
                    begin
                        next_q.bits  = 4'h0;
                        next_q.shreg = read_reg(q, q.ptr);
                        next_q.oe    = ~next_q.shreg[7];
                        next_q.st    = PGDSS_RDATA;
                    end
                default:
                begin
                    next_q.st = PGDSS_IDLE;
                    next_q.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            q <= ST_RESET;
        else
            q <= next_q;
    end

    // Open-drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_o   = q.oe;
    assign shutdown_o = q.shutdown;

    // ==========================================================
    // Power-good delay
    // bypass, shutdown restart
    pgdss_pg_timer #(
        .US_CYCLES (US_CYCLES)
    ) u_pg_timer (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .rails_good_i (rails_good_i & ~q.shutdown),
        .delay_sel_i  (q.pg_sel),
        .bypass_i     (pg_src_bus_i & ~pg_vtt_use_i),
        .bus_level_i  (pg_bus_level_i),
        .pg_o         (power_good_out_c_o)
    );

    // ==========================================================
    // Sleep selection, one per regulator
    logic [7:0]        slp_ctrl [NUM_REGS];
    logic              pin_sel  [NUM_REGS];
    logic [CODE_W-1:0] norm     [NUM_REGS];
    logic [CODE_W-1:0] code     [NUM_REGS];
    logic              sleep    [NUM_REGS];

    assign slp_ctrl[0] = q.slp1;
    assign slp_ctrl[1] = q.slp2;
    assign pin_sel[0]  = reg1_pin_sel_i;
    assign pin_sel[1]  = reg2_pin_sel_i;
    assign norm[0]     = reg1_normal_voltage_code_i;
    assign norm[1]     = reg2_normal_voltage_code_i;

    for (genvar g = 0; g < NUM_REGS; g++)
    begin : g_reg
        pgdss_sleep_sel u_sel (
            .sys_clk_i     (sys_clk_i),
            .reset_i       (reset_i),
            .sleep_en_i    (slp_ctrl[g][SLP_EN_BIT]),
            .pin_sel_i     (pin_sel[g]),
            .sleep_code_i  (slp_ctrl[g][SLP_CODE_LSB +: CODE_W]),
            .normal_code_i (norm[g]),
            .pin_a_i       (q.sy2[2]),
            .pin_b_i       (q.sy2[3]),
            .code_o        (code[g]),
            .sleep_o       (sleep[g])
        );
    end

    assign reg1_voltage_code_o = code[0];
    assign reg1_sleep_o        = sleep[0];
    assign reg2_voltage_code_o = code[1];
    assign reg2_sleep_o        = sleep[1];

    // ==========================================================
    // Checks
    a_sd_no_ack: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        shutdown_o |-> !sda_oe_o ##1 !sda_oe_o)
        else $error("shutdown write was acknowledged");
    a_sd_regs_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        shutdown_o |-> q.pg_sel == PG_SEL_RESET && q.slp1 == SLP_CTRL_RESET
                       && q.slp2 == SLP_CTRL_RESET && q.st == PGDSS_IDLE)
        else $error("registers not reset by shutdown");
    a_sd_self_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        shutdown_o |=> !shutdown_o)
        else $error("shutdown bit did not clear");
    a_sd_cause: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        shutdown_o |-> $past(q.ptr) == ADDR_FORCE_SD && $past(q.shreg[FORCE_SD_BIT]))
        else $error("shutdown without a one written");
    a_ack_after_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        q.st == PGDSS_WDATA && fall && q.bits == BITS_PER_BYTE && q.ptr == ADDR_REG1_SLP
        |=> q.slp1 == $past(q.shreg) && sda_oe_o)
        else $error("sleep register write lost");
    c_sd_taken: cover property (@(posedge sys_clk_i) disable iff (reset_i) shutdown_o);
endmodule

// >>> tb/pgdss_host.sv
// Serial bus controller model that writes and reads device registers
`timescale 1ns/1ps
module pgdss_host #(
    parameter logic [6:0] DEV = 7'h5e  // Device address, arbitrary value
)
(
    // Clock and resolved data wire
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    // Driven pins: clock driven high and low, data open drain
    output logic      scl_o,
    output logic      sda_oe_o
);
    logic r;
    // ==========================================
    // Bus idles released; pins move only after a falling system edge
    initial
    begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic hp(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // One bit: data set in the low phase, sampled at the end of the high phase
    task automatic bt(input logic b, output logic q);
        sda_oe_o = !b;
        hp(10);
        scl_o = 1'b1;
        hp(10);
        q = sda_i;
        scl_o = 1'b0;
        hp(2);
    endtask
    // Byte plus ninth bit; the ninth is always released, so a read ends in NACK
    task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bt(d[i], q[i]);
        bt(1'b1, r);
        ack = !r;
    endtask
    task automatic st();
        sda_oe_o = 1'b0;
        hp(10);
        scl_o = 1'b1;
        hp(10);
        sda_oe_o = 1'b1;
        hp(10);
        scl_o = 1'b0;
        hp(2);
    endtask
    task automatic sp();
        sda_oe_o = 1'b1;
        hp(10);
        scl_o = 1'b1;
        hp(10);
        sda_oe_o = 1'b0;
        hp(10);
    endtask
    // Write one register; ack is high only if all three bytes were answered
    task automatic wr(input logic [7:0] a, d, output logic ack);
        logic [7:0] q;
        logic       k1, k2;
        st();
        xb({DEV, 1'b0}, q, k1);
        xb(a, q, k2);
        xb(d, q, ack);
        ack = ack & k1 & k2;
        sp();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic k;
        st();
        xb({DEV, 1'b0}, q, k);
        xb(a, q, k);
        st();
        xb({DEV, 1'b1}, q, k);
        xb(8'hff, q, k);
        sp();
    endtask
endmodule

// >>> tb/pgdss_top_tb.sv
// Self-checking bench of power-good delay, forced shutdown and sleep selection
`timescale 1ns/1ps
module pgdss_top_tb
    import pgdss_pkg::*;
;
    logic       sys_clk_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic       scl, h_oe, d_oe, pg, s1, s2, sd, ack;
    logic       pa = 1'b1, pb = 1'b1, rg = 1'b0, src = 1'b0, vtt = 1'b0, lvl = 1'b0;
    logic       ps1 = 1'b0, ps2 = 1'b1, sdo;
    logic [6:0] n1 = 7'h11, n2 = 7'h22, c1, c2;
    logic [7:0] q;
    logic [7:0] ad [5] = '{8'h43, 8'h91, 8'h92, 8'h93, 8'h50};
    int         dly [4] = '{2500, 5000, 10000, 15000};
    int         n_errors = 0, n_tests = 0, n_sd = 0;
    wire        sda = (d_oe ? sdo : 1'b1) & !h_oe;

    // ==========================================
    // Device and bus controller; delays scaled to one cycle per microsecond
    pgdss_top #(.US_CYCLES(1)) u_dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sdo), .sda_oe_o(d_oe), .sleep_pin_a_i(pa), .sleep_pin_b_i(pb),
        .reg1_pin_sel_i(ps1), .reg2_pin_sel_i(ps2),
        .reg1_normal_voltage_code_i(n1), .reg2_normal_voltage_code_i(n2),
        .rails_good_i(rg), .pg_src_bus_i(src), .pg_vtt_use_i(vtt), .pg_bus_level_i(lvl),
        .power_good_out_c_o(pg), .reg1_voltage_code_o(c1), .reg1_sleep_o(s1),
        .reg2_voltage_code_o(c2), .reg2_sleep_o(s2), .shutdown_o(sd));
    pgdss_host u_host (
        .sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

    // Clock and shutdown pulse counter
    initial
    begin
        forever #10 sys_clk_i = !sys_clk_i;
    end
    always @(posedge sys_clk_i)
        if (sd === 1'b1)
            n_sd++;

    task automatic chk(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // Pins pass two sync flops and one register before the codes move
    task automatic sl(input logic [7:0] e1, e2);
        u_host.hp(5);
        chk("reg1", {s1, c1}, e1);
        chk("reg2", {s2, c2}, e2);
    endtask
    task automatic rz();
        foreach (ad[i])
        begin
            u_host.rd(ad[i], q);
            chk("reset", q, 8'h00);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: a hung bus or counter ends the run as a failure
    initial
    begin
        #1900000;
        n_errors++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        repeat (6) @(negedge sys_clk_i);
        reset_i = 1'b0;
        u_host.hp(6);
        rz();
        u_host.wr(8'h43, 8'hff, ack);
        u_host.rd(8'h43, q);
        chk("delay_sel", q, 8'h07);
        u_host.wr(8'h92, 8'h81, ack);
        u_host.wr(8'h93, 8'h55, ack);
        u_host.rd(8'h92, q);
        chk("slp1", q, 8'h81);
        sl(8'h11, 8'h22);
        pa = 1'b0;
        sl(8'hc0, 8'h22);
        pa = 1'b1;
        pb = 1'b0;
        sl(8'h11, 8'haa);
        ps1 = 1'b1;
        ps2 = 1'b0;
        sl(8'hc0, 8'h22);
        ps1 = 1'b0;
        ps2 = 1'b1;
        n1 = 7'h33;
        n2 = 7'h44;
        u_host.wr(8'h93, 8'h54, ack);
        sl(8'h33, 8'h44);
        // Full-length delays kept to the four shortest codes for run time
        foreach (dly[i])
        begin
            u_host.wr(8'h43, 8'(i), ack);
            chk("pg_idle", {7'h00, pg}, 8'h00);
            rg = 1'b1;
            u_host.hp(dly[i] * 9 / 10 - 1);
            chk("pg_early", {7'h00, pg}, 8'h00);
            u_host.hp(dly[i] / 5 + 1);
            chk("pg_on", {7'h00, pg}, 8'h01);
            rg = 1'b0;
            u_host.hp(2);
        end
        src = 1'b1;
        lvl = 1'b1;
        u_host.hp(2);
        chk("bypass", {7'h00, pg}, 8'h01);
        vtt = 1'b1;
        u_host.hp(2);
        chk("no_bypass", {7'h00, pg}, 8'h00);
        u_host.wr(8'h91, 8'h00, ack);
        chk("sd0_ack", {7'h00, ack}, 8'h01);
        chk("sd0_idle", n_sd[7:0], 8'h00);
        u_host.wr(8'h91, 8'h01, ack);
        chk("sd1_ack", {7'h00, ack}, 8'h00);
        chk("sd1_pulse", n_sd[7:0], 8'h01);
        rz();
        sl(8'h33, 8'h44);
        finish_test();
    end
endmodule
